/* adc_repeat_sweep_sequencer_tb.sv */
`default_nettype none
`include "adcs_regs.vh"
module adc_repeat_sweep_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_mclk;
  logic        i_arst_n;
  logic        wb_cyc;
  logic        wb_we;
  logic [7:0]  wb_adr;
  logic [31:0] wb_wdat;
  wire  [31:0] wb_rdat;
  wire         wb_ack;
  wire  [9:0]  sar;
  wire  [2:0]  pin_sel;
  wire         alt;
  logic [31:0] q;
  logic [15:0] cyc_cnt;
  int          err_total;
  int          compares;
  localparam logic [31:0] mask_all = 32'hFFFF_FFFF;

  adcs_seq u_dut (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_wb_cyc(wb_cyc),
    .i_wb_stb(wb_cyc), .i_wb_we(wb_we), .i_wb_adr(wb_adr),
    .i_wb_sel(4'hF), .i_wb_dat(wb_wdat), .o_wb_dat(wb_rdat),
    .o_wb_ack(wb_ack), .i_sar_data(sar), .o_analog_input_n(pin_sel),
    .o_alternate_port_group(alt), .o_conv_start(), .o_converting(),
    .o_sh_en(), .o_vref_en(), .o_res10(), .o_fad_en());
  adcs_src u_src (.i_sel(pin_sel), .i_alt(alt), .o_sar(sar));

  // 250 MHz clock
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end

  // hang guard
  always @(posedge i_mclk) begin
    cyc_cnt <= cyc_cnt + 16'h0001;
    if (cyc_cnt == 16'h1388) begin
      err_total++;
      summarize();
    end
  end

  // expected result register contents for a pin
  function automatic logic [31:0] ex(input logic a, input logic [2:0] i,
                                     input logic r);
    logic [9:0] v;
    v = a ? {3'h5, i, 4'hA} : {3'h2, i, 4'h6};
    ex = r ? {22'h0, v} : {24'h0, v[9:2]};
  endfunction

  // one classic bus cycle, read data left in q
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge i_mclk);
    wb_cyc  <= 1'b1;
    wb_we   <= w;
    wb_adr  <= a;
    wb_wdat <= d;
    do @(posedge i_mclk); while (wb_ack !== 1'b1);
    q = wb_rdat;
    wb_cyc  <= 1'b0;
    @(posedge i_mclk);
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask

  // masked register read and compare
  task automatic rc(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask

  // sweep 0 over four pins, 10-bit, hold on, undivided
  task automatic s_rsw0();
    wb(1'b1, `ADCS_ADR_CTRL1, 32'h35);
    wb(1'b1, `ADCS_ADR_CTRL0, 32'h10);
    wb(1'b1, `ADCS_ADR_CTRL0, 32'h50);
    repeat (300) @(posedge i_mclk);
    wb(1'b1, `ADCS_ADR_CTRL0, 32'h10);
    for (int i = 0; i < 4; i++)
      rc(8'h20 + 8'(4 * i), mask_all, ex(1'b0, 3'(i), 1'b1));
    rc(8'h30, mask_all, 32'h0);
    rc(`ADCS_ADR_STAT, 32'h3, 32'h0);
    rc(8'h80, mask_all, 32'h0);
  endtask

  // sweep 1, three pins of the alternate group, 8-bit, halved
  task automatic s_rsw1();
    wb(1'b1, `ADCS_ADR_CTRL1, 32'h0A);
    wb(1'b1, `ADCS_ADR_CTRL0, 32'h18);
    wb(1'b1, `ADCS_ADR_CTRL0, 32'h38);
    wb(1'b1, `ADCS_ADR_CTRL0, 32'h78);
    repeat (700) @(posedge i_mclk);
    rc(`ADCS_ADR_STAT, 32'h3, 32'h2);
    wb(1'b1, `ADCS_ADR_CTRL0, 32'h38);
    for (int i = 0; i < 3; i++)
      rc(8'h20 + 8'(4 * i), mask_all, ex(1'b1, 3'(i), 1'b0));
    rc(8'h2C, mask_all, ex(1'b0, 3'h3, 1'b1));
  endtask

  // sweep 1 with a single pin, quarter rate
  task automatic s_one();
    wb(1'b1, `ADCS_ADR_CTRL1, 32'h20);
    wb(1'b1, `ADCS_ADR_CTRL0, 32'h18);
    wb(1'b1, `ADCS_ADR_CTRL0, 32'h58);
    repeat (400) @(posedge i_mclk);
    wb(1'b1, `ADCS_ADR_CTRL0, 32'h18);
    rc(8'h20, mask_all, ex(1'b0, 3'h0, 1'b0));
    rc(8'h24, mask_all, ex(1'b1, 3'h1, 1'b0));
  endtask

  // poll the request bit until completion shows
  task automatic wait_done();
    do wb(1'b0, `ADCS_ADR_STAT, 32'h0); while (q[0] !== 1'b1);
  endtask

  // single sweep of four pins, low-supply setup, then request clear
  task automatic s_single();
    wb(1'b1, `ADCS_ADR_CTRL1, 32'h11);
    wb(1'b1, `ADCS_ADR_CTRL0, 32'h08);
    wb(1'b1, `ADCS_ADR_CTRL0, 32'h48);
    wait_done();
    for (int i = 0; i < 4; i++)
      rc(8'h20 + 8'(4 * i), mask_all, ex(1'b0, 3'(i), 1'b0));
    rc(8'h30, mask_all, 32'h0);
    rc(`ADCS_ADR_STAT, 32'h3, 32'h1);
    rc(`ADCS_ADR_CTRL0, 32'h40, 32'h0);
    wb(1'b1, `ADCS_ADR_STAT, 32'h0);
    rc(`ADCS_ADR_STAT, 32'h3, 32'h0);
  endtask

  // one-shot of a chosen channel, 10-bit, then reference readback
  task automatic s_oneshot();
    wb(1'b1, `ADCS_ADR_CTRL1, 32'h14);
    wb(1'b1, `ADCS_ADR_CTRL0, 32'h00);
    wb(1'b1, `ADCS_ADR_CTRL0, 32'h05);
    wb(1'b1, `ADCS_ADR_CTRL0, 32'h45);
    wait_done();
    rc(8'h34, mask_all, ex(1'b0, 3'h5, 1'b1));
    rc(8'h30, mask_all, 32'h0);
    rc(`ADCS_ADR_CTRL0, 32'h47, 32'h05);
    wb(1'b1, `ADCS_ADR_CTRL1, 32'h54);
    rc(`ADCS_ADR_CTRL1, mask_all, 32'h54);
  endtask

  task automatic summarize();
    if (err_total == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // reset, then the scenarios
  initial begin
    i_arst_n  = 1'b0;
    wb_cyc    = 1'b0;
    wb_we     = 1'b0;
    wb_adr    = 8'h00;
    wb_wdat   = 32'h0;
    q         = 32'h0;
    cyc_cnt   = 16'h0000;
    err_total = 0;
    compares  = 0;
    repeat (5) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    s_rsw0();
    s_rsw1();
    s_one();
    s_single();
    s_oneshot();
    summarize();
  end
endmodule // adc_repeat_sweep_sequencer_tb
`default_nettype wire

/* adcs_fdiv.v */
`default_nettype none
`include "adcs_regs.vh"

module adcs_fdiv (
  // clock and reset
  input  wire       i_mclk,
  input  wire       i_arst_n,
  // control
  input  wire [1:0] i_div,
  input  wire       i_run,
  // converter clock enable
  output reg        o_fad_en_r
);

  reg  [1:0] cnt_r;
  reg  [1:0] end_cnt;

  // terminal count per selected division
  always @* begin
    case (i_div)
      `ADCS_DIV4: end_cnt = `ADCS_DIV4_END;
      `ADCS_DIV2: end_cnt = `ADCS_DIV2_END;
      default:    end_cnt = `ADCS_DIV1_END;
    endcase
  end

  // divider restarts whenever conversion halts
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r      <= 2'h0;
      o_fad_en_r <= 1'b0;
    end else if (!i_run) begin
      cnt_r      <= 2'h0;
      o_fad_en_r <= 1'b0;
    end else if (cnt_r >= end_cnt) begin
      cnt_r      <= 2'h0;
      o_fad_en_r <= 1'b1;
    end else begin
      cnt_r      <= cnt_r + 2'h1;
      o_fad_en_r <= 1'b0;
    end
  end

endmodule // adcs_fdiv

`default_nettype wire

/* adcs_props.sv */
`default_nettype none
`include "adcs_regs.vh"
module adcs_props (
  // clock and reset
  input wire logic        i_mclk,
  input wire logic        i_arst_n,
  // bus
  input wire logic        i_wb_we,
  input wire logic [7:0]  i_wb_adr,
  input wire logic [3:0]  i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic        o_wb_ack,
  // front end
  input wire logic [2:0]  o_analog_input_n,
  input wire logic        o_alternate_port_group,
  input wire logic        o_conv_start,
  input wire logic        o_converting,
  input wire logic        o_sh_en,
  input wire logic        o_vref_en,
  input wire logic        o_res10,
  input wire logic        o_fad_en
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] mode_m;
  logic [1:0] swp_m;
  logic [1:0] div_m;
  logic       alt_m;
  logic       res_m;
  logic       sh_m;
  logic       vref_m;
  logic       vld_r;
  logic [2:0] idx_r;
  logic [6:0] cnt_r;
  wire        wr = o_wb_ack & i_wb_we & i_wb_sel[0];
  wire        wr0 = wr & (i_wb_adr == `ADCS_ADR_CTRL0);
  wire        wr1 = wr & (i_wb_adr == `ADCS_ADR_CTRL1);
  // converter cycles per input: 33, 28, 59, 49
  wire  [6:0] n_len = o_sh_en ? (o_res10 ? 7'h21 : 7'h1C)
                              : (o_res10 ? 7'h3B : 7'h31);

  // shadow of control fields, updated as a write lands
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_m <= 2'h0;
      alt_m  <= 1'h0;
      swp_m  <= 2'h0;
      div_m  <= 2'h0;
      res_m  <= 1'h0;
      sh_m   <= 1'h0;
      vref_m <= 1'h0;
    end else if (wr0) begin
      mode_m <= i_wb_dat[4:3];
      alt_m  <= i_wb_dat[5];
    end else if (wr1) begin
      swp_m  <= i_wb_dat[1:0];
      div_m  <= i_wb_dat[4:3];
      res_m  <= i_wb_dat[2];
      sh_m   <= i_wb_dat[5];
      vref_m <= i_wb_dat[6];
    end
  end

  // last input started and converter pulses since then
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      vld_r <= 1'h0;
      idx_r <= 3'h0;
      cnt_r <= 7'h00;
    end else if (o_conv_start) begin
      vld_r <= 1'h1;
      idx_r <= o_analog_input_n;
      cnt_r <= {6'h00, o_fad_en};
    end else begin
      vld_r <= vld_r & o_converting;
      cnt_r <= cnt_r + {6'h00, o_fad_en};
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  a_conv_len: assert property (
    o_conv_start && vld_r && o_converting |-> cnt_r == n_len)
    else $error("conversion length wrong");
  a_rsw0_step: assert property (
    o_conv_start && vld_r && o_converting && mode_m == `ADCS_MODE_RSW0
    |-> o_analog_input_n == ((idx_r == {swp_m, 1'h1}) ? 3'h0 : idx_r + 3'h1))
    else $error("sweep 0 order wrong");
  a_rsw1_back: assert property (
    o_conv_start && vld_r && o_converting && mode_m == `ADCS_MODE_RSW1
    && idx_r != 3'h0 |-> o_analog_input_n == 3'h0)
    else $error("first input not interleaved");
  a_rsw1_group: assert property (
    o_conv_start && mode_m == `ADCS_MODE_RSW1
    |-> o_analog_input_n <= {1'h0, swp_m})
    else $error("input outside sweep group");
  a_first_in: assert property (
    o_conv_start && !o_converting && mode_m != `ADCS_MODE_ONE
    |-> o_analog_input_n == 3'h0)
    else $error("run did not begin at first input");
  a_start_go: assert property (
    wr0 && i_wb_dat[6] && !o_converting |-> ##[1:4] o_conv_start)
    else $error("start flag did not launch");
  a_stop_halt: assert property (
    wr0 && !i_wb_dat[6] |-> ##3 (!o_converting && !o_conv_start)[*2])
    else $error("clearing start did not stop");
  a_fad_quarter: assert property (
    o_fad_en && div_m == `ADCS_DIV4 |=> !o_fad_en [*3])
    else $error("divide by four rate wrong");
  a_fad_half: assert property (
    o_fad_en && div_m == `ADCS_DIV2 |=> !o_fad_en)
    else $error("divide by two rate wrong");
  a_alt_copy: assert property (
    o_alternate_port_group == $past(alt_m))
    else $error("pin group select wrong");
  a_ctl1_copy: assert property (
    {o_vref_en, o_sh_en, o_res10} == $past({vref_m, sh_m, res_m}))
    else $error("control 1 copies wrong");

  // main scenarios
  c_wrap: cover property (o_conv_start && vld_r && idx_r == 3'h3);
  c_back: cover property (o_conv_start && idx_r == 3'h2 && mode_m[0]);
  c_stop: cover property (wr0 && !i_wb_dat[6] && o_converting);
endmodule // adcs_props

bind adcs_seq adcs_props u_props (
  .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_wb_we(i_wb_we),
  .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
  .o_wb_ack(o_wb_ack), .o_analog_input_n(o_analog_input_n),
  .o_alternate_port_group(o_alternate_port_group),
  .o_conv_start(o_conv_start), .o_converting(o_converting),
  .o_sh_en(o_sh_en), .o_vref_en(o_vref_en), .o_res10(o_res10),
  .o_fad_en(o_fad_en));
`default_nettype wire

/* adcs_regs.vh */
// What this block does
// - sample-and-hold conversion lasts 28 cycles (8-bit) or 33 cycles (10-bit)
// - repeat sweep 0 converts first input then each selected one, forever
// - per-input rate is 49 cycles (8-bit) or 59 cycles (10-bit)
// - converter clock is source clock divided by four, two, or one
// - alternate port group routes inputs from alternate-group pins instead
// - writing one to start flag starts converting the first input, or the chosen channel in one-shot mode
// - first input result goes to result register 0
// - repeat sweep 1 converts first input again after each other input
// - each completed conversion writes its own input's result register
// - repeat sweep modes never set the conversion request bit
// - repeat sweeps run until software clears start flag, which stops them
// - single modes set request bit at completion; software checks it first
`ifndef ADCS_REGS_VH
`define ADCS_REGS_VH

// register byte offsets
`define ADCS_ADR_CTRL0    8'h00
`define ADCS_ADR_CTRL1    8'h04
`define ADCS_ADR_STAT     8'h08
`define ADCS_RES_HI       3'h1
`define ADCS_ADR_BLK_HI   7
`define ADCS_ADR_BLK_LO   5
`define ADCS_ADR_IDX_HI   4
`define ADCS_ADR_IDX_LO   2
`define ADCS_NUM_RES      8
// control 0 fields
`define ADCS_C0_CH_HI     2
`define ADCS_C0_CH_LO     0
`define ADCS_C0_MODE_HI   4
`define ADCS_C0_MODE_LO   3
`define ADCS_C0_ALT       5
`define ADCS_C0_START     6
// control 1 fields
`define ADCS_C1_SWP_HI    1
`define ADCS_C1_SWP_LO    0
`define ADCS_C1_RES10     2
`define ADCS_C1_DIV_HI    4
`define ADCS_C1_DIV_LO    3
`define ADCS_C1_SH        5
`define ADCS_C1_VREF      6
// status fields
`define ADCS_ST_IRQ       0
`define ADCS_ST_RUN       1
`define ADCS_ST_CUR_HI    4
`define ADCS_ST_CUR_LO    2
// modes
`define ADCS_MODE_ONE     2'h0
`define ADCS_MODE_SSWP    2'h1
`define ADCS_MODE_RSW0    2'h2
`define ADCS_MODE_RSW1    2'h3
// divider selections
`define ADCS_DIV4         2'h0
`define ADCS_DIV2         2'h1
`define ADCS_DIV4_END     2'h3
`define ADCS_DIV2_END     2'h1
`define ADCS_DIV1_END     2'h0
// last converter-clock count of one input (cycles minus one)
`define ADCS_END_SH8      6'h1B
`define ADCS_END_SH10     6'h20
`define ADCS_END_RATE8    6'h30
`define ADCS_END_RATE10   6'h3A
// reset values
`define ADCS_CH_RST       3'h0
`define ADCS_CNT_RST      6'h00
`define ADCS_RES_RST      10'h000
`define ADCS_DAT_RST      32'h0000_0000

`endif

/* adcs_seq.v */
`default_nettype none
`include "adcs_regs.vh"

module adcs_seq (
  // clock and reset
  input  wire        i_mclk,
  input  wire        i_arst_n,
  // wishbone slave
  input  wire        i_wb_cyc,
  input  wire        i_wb_stb,
  input  wire        i_wb_we,
  input  wire [7:0]  i_wb_adr,
  input  wire [3:0]  i_wb_sel,
  input  wire [31:0] i_wb_dat,
  output reg  [31:0] o_wb_dat,
  output reg         o_wb_ack,
  // successive comparison result from analog core
  input  wire [9:0]  i_sar_data,
  // analog front end control
  output reg  [2:0]  o_analog_input_n,
  output reg         o_alternate_port_group,
  output reg         o_conv_start,
  output reg         o_converting,
  output reg         o_sh_en,
  output reg         o_vref_en,
  output reg         o_res10,
  output wire        o_fad_en
);

  // control 0 state
  reg  [2:0] ch_r;
  reg  [1:0] mode_r;
  reg        alt_r;
  reg        start_r;
  // control 1 state
  reg  [1:0] swp_r;
  reg        res10_r;
  reg  [1:0] div_r;
  reg        sh_r;
  reg        vref_r;
  // status and sequencing
  reg        irq_r;
  reg        run_r;
  reg  [2:0] cur_r;
  reg  [2:0] other_r;
  reg  [5:0] cnt_r;
  // result storage
  reg  [9:0] res_r [0:7];
  // input synchroniser
  reg  [9:0] sar_s1_r;
  reg  [9:0] sar_s2_r;
  // combinational terms
  reg  [5:0] end_cnt;
  reg  [2:0] cur_nxt;
  reg  [2:0] other_nxt;
  reg        done_nxt;
  reg  [2:0] ain_nxt;
  reg        cst_nxt;
  reg [31:0] rd_dat;
  wire       fad_en;
  wire       req;
  wire       wr;
  wire       wr_c0;
  wire       wr_c1;
  wire       wr_st;
  wire       eoc;
  wire       launch;
  wire [2:0] last0;
  wire [2:0] last1;
  wire [2:0] first_ch;
  wire [9:0] result;
  wire       sweep_rep;
  integer    i;

  // converter clock enable divider
  adcs_fdiv u_fdiv (
    .i_mclk     (i_mclk),
    .i_arst_n   (i_arst_n),
    .i_div      (div_r),
    .i_run      (run_r),
    .o_fad_en_r (fad_en)
  );

  assign o_fad_en = fad_en;

  // bus decode; writes land on the acknowledging edge
  assign req   = i_wb_cyc & i_wb_stb;
  assign wr    = req & i_wb_we & o_wb_ack & i_wb_sel[0];
  assign wr_c0 = wr & (i_wb_adr == `ADCS_ADR_CTRL0);
  assign wr_c1 = wr & (i_wb_adr == `ADCS_ADR_CTRL1);
  assign wr_st = wr & (i_wb_adr == `ADCS_ADR_STAT);

  // sweep extents: pairs in sweep 0, group of one to four in sweep 1
  assign last0 = {swp_r, 1'b1};
  assign last1 = {1'b0, swp_r};

  // one-shot uses the chosen channel, the others start at input 0
  assign first_ch = (mode_r == `ADCS_MODE_ONE) ? ch_r : `ADCS_CH_RST;

  assign sweep_rep = (mode_r == `ADCS_MODE_RSW0) |
                     (mode_r == `ADCS_MODE_RSW1);

  // start flag seen while idle launches the sequence
  assign launch = start_r & ~run_r;

  // conversion of one input ends on its last converter clock
  assign eoc = run_r & fad_en & (cnt_r == end_cnt);

  // 8-bit results are the upper bits of the comparison register
  assign result = res10_r ? sar_s2_r : {2'h0, sar_s2_r[9:2]};

  // cycles per input from resolution and sample-and-hold
  always @* begin
    case ({sh_r, res10_r})
      2'b11:   end_cnt = `ADCS_END_SH10;
      2'b10:   end_cnt = `ADCS_END_SH8;
      2'b01:   end_cnt = `ADCS_END_RATE10;
      default: end_cnt = `ADCS_END_RATE8;
    endcase
  end

  // next input to convert after the current one
  always @* begin
    cur_nxt   = cur_r;
    other_nxt = other_r;
    done_nxt  = 1'b0;
    case (mode_r)
      `ADCS_MODE_ONE: begin
        done_nxt = 1'b1;
      end
      `ADCS_MODE_SSWP: begin
        if (cur_r == last0) begin
          done_nxt = 1'b1;
        end else begin
          cur_nxt = cur_r + 3'h1;
        end
      end
      `ADCS_MODE_RSW0: begin
        if (cur_r == last0) begin
          cur_nxt = `ADCS_CH_RST;
        end else begin
          cur_nxt = cur_r + 3'h1;
        end
      end
      `ADCS_MODE_RSW1: begin
        if (cur_r != `ADCS_CH_RST) begin
          cur_nxt = `ADCS_CH_RST;
          if (cur_r == last1) begin
            other_nxt = 3'h1;
          end else begin
            other_nxt = cur_r + 3'h1;
          end
        end else if (last1 == `ADCS_CH_RST) begin
          cur_nxt = `ADCS_CH_RST;
        end else begin
          cur_nxt = other_r;
        end
      end
      default: begin
        done_nxt = 1'b1;
      end
    endcase
  end

  // input index and start pulse for the coming conversion
  always @* begin
    ain_nxt = cur_r;
    cst_nxt = 1'b0;
    if (launch) begin
      ain_nxt = first_ch;
      cst_nxt = 1'b1;
    end else if (eoc) begin
      ain_nxt = cur_nxt;
      cst_nxt = ~done_nxt & start_r;
    end
  end

  // two-stage capture of the analog core result
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sar_s1_r <= `ADCS_RES_RST;
      sar_s2_r <= `ADCS_RES_RST;
    end else begin
      sar_s1_r <= i_sar_data;
      sar_s2_r <= sar_s1_r;
    end
  end

  // control 0; software write wins over the hardware stop
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ch_r    <= `ADCS_CH_RST;
      mode_r  <= `ADCS_MODE_ONE;
      alt_r   <= 1'b0;
      start_r <= 1'b0;
    end else if (wr_c0) begin
      ch_r    <= i_wb_dat[`ADCS_C0_CH_HI:`ADCS_C0_CH_LO];
      mode_r  <= i_wb_dat[`ADCS_C0_MODE_HI:`ADCS_C0_MODE_LO];
      alt_r   <= i_wb_dat[`ADCS_C0_ALT];
      start_r <= i_wb_dat[`ADCS_C0_START];
    end else if (eoc & done_nxt) begin
      start_r <= 1'b0;
    end
  end

  // control 1
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      swp_r   <= 2'h0;
      res10_r <= 1'b0;
      div_r   <= `ADCS_DIV4;
      sh_r    <= 1'b0;
      vref_r  <= 1'b0;
    end else if (wr_c1) begin
      swp_r   <= i_wb_dat[`ADCS_C1_SWP_HI:`ADCS_C1_SWP_LO];
      res10_r <= i_wb_dat[`ADCS_C1_RES10];
      div_r   <= i_wb_dat[`ADCS_C1_DIV_HI:`ADCS_C1_DIV_LO];
      sh_r    <= i_wb_dat[`ADCS_C1_SH];
      vref_r  <= i_wb_dat[`ADCS_C1_VREF];
    end
  end

  // completion request bit; a completion beats a software clear
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_r <= 1'b0;
    end else if (eoc & done_nxt & ~sweep_rep) begin
      irq_r <= 1'b1;
    end else if (wr_st & ~i_wb_dat[`ADCS_ST_IRQ]) begin
      irq_r <= 1'b0;
    end
  end
  // repeat sweeps never reach done_nxt, so the bit stays untouched

  // sequencer: launch, count, advance, stop
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      run_r   <= 1'b0;
      cur_r   <= `ADCS_CH_RST;
      other_r <= 3'h1;
      cnt_r   <= `ADCS_CNT_RST;
    end else if (!start_r) begin
      run_r <= 1'b0;
      cnt_r <= `ADCS_CNT_RST;
    end else if (launch) begin
      run_r   <= 1'b1;
      cur_r   <= first_ch;
      other_r <= 3'h1;
      cnt_r   <= `ADCS_CNT_RST;
    end else if (eoc) begin
      cnt_r   <= `ADCS_CNT_RST;
      cur_r   <= cur_nxt;
      other_r <= other_nxt;
      if (done_nxt) begin
        run_r <= 1'b0;
      end
    end else if (fad_en) begin
      cnt_r <= cnt_r + 6'h01;
    end
  end

  // each finished input writes its own result register
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (i = 0; i < `ADCS_NUM_RES; i = i + 1) begin
        res_r[i] <= `ADCS_RES_RST;
      end
    end else if (eoc) begin
      res_r[cur_r] <= result;
    end
  end

  // front end controls from flops
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_analog_input_n       <= `ADCS_CH_RST;
      o_alternate_port_group <= 1'b0;
      o_conv_start           <= 1'b0;
      o_converting           <= 1'b0;
      o_sh_en                <= 1'b0;
      o_vref_en              <= 1'b0;
      o_res10                <= 1'b0;
    end else begin
      o_analog_input_n       <= ain_nxt;
      o_alternate_port_group <= alt_r;
      o_conv_start           <= cst_nxt;
      o_converting           <= run_r;
      o_sh_en                <= sh_r;
      o_vref_en              <= vref_r;
      o_res10                <= res10_r;
    end
  end

  // read data multiplexer
  always @* begin
    rd_dat = `ADCS_DAT_RST;
    if (i_wb_adr[`ADCS_ADR_BLK_HI:`ADCS_ADR_BLK_LO] == `ADCS_RES_HI) begin
      rd_dat[9:0] = res_r[i_wb_adr[`ADCS_ADR_IDX_HI:`ADCS_ADR_IDX_LO]];
    end else begin
      case (i_wb_adr)
        `ADCS_ADR_CTRL0: begin
          rd_dat[`ADCS_C0_CH_HI:`ADCS_C0_CH_LO]     = ch_r;
          rd_dat[`ADCS_C0_MODE_HI:`ADCS_C0_MODE_LO] = mode_r;
          rd_dat[`ADCS_C0_ALT]                      = alt_r;
          rd_dat[`ADCS_C0_START]                    = start_r;
        end
        `ADCS_ADR_CTRL1: begin
          rd_dat[`ADCS_C1_SWP_HI:`ADCS_C1_SWP_LO] = swp_r;
          rd_dat[`ADCS_C1_RES10]                  = res10_r;
          rd_dat[`ADCS_C1_DIV_HI:`ADCS_C1_DIV_LO] = div_r;
          rd_dat[`ADCS_C1_SH]                     = sh_r;
          rd_dat[`ADCS_C1_VREF]                   = vref_r;
        end
        `ADCS_ADR_STAT: begin
          rd_dat[`ADCS_ST_IRQ] = irq_r;
          rd_dat[`ADCS_ST_RUN] = run_r;
          rd_dat[`ADCS_ST_CUR_HI:`ADCS_ST_CUR_LO] = cur_r;
        end
        default: begin
          rd_dat = `ADCS_DAT_RST;
        end
      endcase
    end
  end

  // one wait state, ack drops the cycle after it rises
  always @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= `ADCS_DAT_RST;
    end else begin
      o_wb_ack <= req & ~o_wb_ack;
      if (req & ~o_wb_ack) begin
        o_wb_dat <= rd_dat;
      end
    end
  end

endmodule // adcs_seq

`default_nettype wire

/* adcs_src.sv */
`default_nettype none
module adcs_src (
  // input selection from the sequencer
  input  wire logic [2:0] i_sel,
  input  wire logic       i_alt,
  // level seen by the comparison core
  output logic      [9:0] o_sar
);
  timeunit 1ns;
  timeprecision 1ps;

  // every pin of both groups carries its own distinct level
  assign o_sar = i_alt ? {3'h5, i_sel, 4'hA} : {3'h2, i_sel, 4'h6};
endmodule // adcs_src
`default_nettype wire
